// ### tmrwg_pkg.sv
// Package with register map, field layout, mode codes and mode record type of the timer waveform block
// Operation
// - A nonzero channel action field routes that channel's compare output onto its pin, except code 01 in PWM modes on channel B or without toggle.
// - Non-PWM actions: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clears on match, sets at TOP; 11 the inverse.
// - Fast PWM code 01 toggles channel A only in modes 14, 15; else disconnects.
// - Fast PWM: compare equal to TOP with upper bit set ignores match.
// - Dual-slope: 10 clears on up-count match, sets on down-count match; 11 inverse.
// - Dual-slope code 01 toggles channel A only in modes 8 to 11.
// - Mode is two bits of control A plus two bits of control B.
// - Modes 0, 4, 12 count normally or clear on match; immediate update, overflow at MAX.
// - Phase correct 1, 2, 3 fixed TOP; 10 capture, 11 compare A; reload TOP, flag BOTTOM.
// - Modes 8, 9 take TOP from capture or compare A; reload and flag at BOTTOM.
// - Fast PWM 5, 6, 7 fixed TOP; 14 capture, 15 compare A; reload and flag at TOP.
// - Control B: filter bit 7, edge bit 6, zero bit 5, mode 4:3, clock 2:0.
// - Dual-slope counter runs up to TOP then down to zero repeatedly.
// - Dual-slope code 10: compare at BOTTOM holds output low, at TOP holds it high; 11 inverse.
package tmrwg_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] TMRWG_OFF_CTRL_A = 8'h00;
    localparam logic [7:0] TMRWG_OFF_CTRL_B = 8'h04;
    localparam logic [7:0] TMRWG_OFF_CMP_A = 8'h08;
    localparam logic [7:0] TMRWG_OFF_CMP_B = 8'h0C;
    localparam logic [7:0] TMRWG_OFF_CAPT = 8'h10;
    localparam logic [7:0] TMRWG_OFF_COUNT = 8'h14;
    localparam logic [7:0] TMRWG_OFF_IRQ_STAT = 8'h18;
    localparam logic [7:0] TMRWG_OFF_IRQ_CLR = 8'h1C;
    localparam logic [7:0] TMRWG_OFF_IRQ_EN = 8'h20;
    // ==========================================================
    // Field positions and reset values
    localparam int TMRWG_A_ACT_A_LSB = 6;
    localparam int TMRWG_A_ACT_B_LSB = 4;
    localparam int TMRWG_B_FILT_BIT = 7;
    localparam int TMRWG_B_EDGE_BIT = 6;
    localparam int TMRWG_B_MODE_LSB = 3;
    localparam logic [7:0] TMRWG_CTRL_A_WMASK = 8'hF3;
    localparam logic [7:0] TMRWG_CTRL_B_WMASK = 8'hDF;
    localparam logic [7:0] TMRWG_CTRL_RESET = 8'h00;
    localparam logic [15:0] TMRWG_MAX = 16'hFFFF;
    localparam logic [15:0] TMRWG_TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TMRWG_TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TMRWG_TOP_10BIT = 16'h03FF;
    localparam logic [1:0] TMRWG_IRQ_OVF = 2'h0;
    localparam logic [1:0] TMRWG_IRQ_MA = 2'h1;
    localparam logic [1:0] TMRWG_IRQ_MB = 2'h2;
    // ==========================================================
    // Waveform kinds and TOP sources
    typedef enum logic [1:0] {
        TMRWG_KIND_NONPWM = 2'h0,
        TMRWG_KIND_FAST = 2'h1,
        TMRWG_KIND_DUAL = 2'h3
    } tmrwg_kind_t;
    typedef enum logic [1:0] {
        TMRWG_TOP_FIXED = 2'h0,
        TMRWG_TOP_CMPA = 2'h1,
        TMRWG_TOP_CAPT = 2'h2
    } tmrwg_topsrc_t;
    typedef enum logic [1:0] {
        TMRWG_EVT_MAX = 2'h0,
        TMRWG_EVT_TOP = 2'h1,
        TMRWG_EVT_BOTTOM = 2'h2,
        TMRWG_EVT_NOW = 2'h3
    } tmrwg_evt_t;
    typedef struct packed {
        tmrwg_kind_t kind;
        tmrwg_topsrc_t top_src;
        logic [15:0] fixed_top;
        tmrwg_evt_t reload_at;
        tmrwg_evt_t ovf_at;
        logic toggle_ok;
    } tmrwg_mode_t;
endpackage

// ### tmrwg_chan.sv
// One compare output channel: action decode, output register and pin mux
`timescale 1ns/1ps
`default_nettype none
module tmrwg_chan
    import tmrwg_pkg::*;
#(
    parameter bit IS_CHAN_A = 1'b1
) (
    input wire logic mclk,
    input wire logic reset,
    input wire tmrwg_mode_t mode,
    input wire logic [1:0] action,
    input wire logic tick,
    input wire logic match,
    input wire logic at_top,
    input wire logic at_bottom,
    input wire logic up,
    input wire logic cmp_is_top,
    input wire logic cmp_is_bot,
    input wire logic port_data,
    output logic wave_out,
    output logic pin_out,
    output logic connected
);
    logic wave_q;
    logic wave_d;
    logic tog_ok;
    logic tog_match;
    logic dual_fix;
    assign tog_ok = IS_CHAN_A && mode.toggle_ok;
    assign tog_match = match && (action == 2'h1) && ((mode.kind == TMRWG_KIND_NONPWM) || tog_ok);
    // Dual-slope extremes are held statically so the pin never glitches on BOTTOM or TOP
    assign dual_fix = cmp_is_bot || cmp_is_top;
    assign connected = (action != 2'h0) && ((mode.kind == TMRWG_KIND_NONPWM) ||
        (action[1] == 1'b1) || tog_ok);
    always_comb begin
        wave_d = wave_q;
        if (tick) begin
            if (tog_match) begin
                wave_d = ~wave_q;
            end else if (mode.kind == TMRWG_KIND_NONPWM) begin
                if (match && action[1]) begin
                    wave_d = action[0];
                end
            end else if (mode.kind == TMRWG_KIND_FAST && action[1]) begin
                if (at_top) begin
                    wave_d = ~action[0];
                end else if (match && !cmp_is_top) begin
                    wave_d = action[0];
                end
            end else if (mode.kind == TMRWG_KIND_DUAL && action[1]) begin
                if (dual_fix) begin
                    wave_d = cmp_is_top ^ action[0];
                end else if (match) begin
                    wave_d = up ? action[0] : ~action[0];
                end
            end
        end
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wave_q <= 1'b0;
        end else begin
            wave_q <= wave_d;
        end
    end
    assign wave_out = wave_q;
    assign pin_out = connected ? wave_q : port_data;
    chk_fast_top_sets: assert property (@(posedge mclk) disable iff (reset)
        (tick && at_top && mode.kind == TMRWG_KIND_FAST && action == 2'h2 && !tog_match)
        |=> wave_q == 1'b1) else $error("fast pwm top did not set output");
    chk_pin_mux: assert property (@(posedge mclk) disable iff (reset)
        connected |-> pin_out == wave_q) else $error("pin not showing compare output");
    chk_nonpwm_toggle: assert property (@(posedge mclk) disable iff (reset)
        (tick && match && action == 2'h1 && mode.kind == TMRWG_KIND_NONPWM)
        |=> wave_q != $past(wave_q)) else $error("toggle on match missing");
endmodule
`default_nettype wire

// ### tmrwg_top.sv
// Timer waveform mode decode with counter, compare channels and AHB-Lite registers
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tmrwg_top
    import tmrwg_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic port_data_a,
    input wire logic port_data_b,
    output logic chan_a_wave_out,
    output logic chan_b_wave_out,
    output logic pin_a_out,
    output logic pin_b_out,
    output logic pin_a_connected,
    output logic pin_b_connected,
    output logic irq
);
    // ==========================================================
    // Bus slave
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [7:0] rd_addr;
    logic take;
    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_b_q;
    logic [CNT_W-1:0] cmp_a_buf_q;
    logic [CNT_W-1:0] cmp_b_buf_q;
    logic [CNT_W-1:0] cmp_a_q;
    logic [CNT_W-1:0] cmp_b_q;
    logic [CNT_W-1:0] capt_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic up_q;
    logic [2:0] stat_q;
    logic [2:0] stat_d;
    logic [2:0] irq_en_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic wr_ctrl_a;
    logic wr_ctrl_b;
    logic wr_cmp_a;
    logic wr_cmp_b;
    logic wr_capt;
    logic wr_count;
    logic wr_clr;
    logic wr_en;
    assign take = hsel && hready && htrans[1];
    assign rd_addr = haddr[7:0];
    assign wr_ctrl_a = wr_pend_q && (wr_addr_q == TMRWG_OFF_CTRL_A);
    assign wr_ctrl_b = wr_pend_q && (wr_addr_q == TMRWG_OFF_CTRL_B);
    assign wr_cmp_a = wr_pend_q && (wr_addr_q == TMRWG_OFF_CMP_A);
    assign wr_cmp_b = wr_pend_q && (wr_addr_q == TMRWG_OFF_CMP_B);
    assign wr_capt = wr_pend_q && (wr_addr_q == TMRWG_OFF_CAPT);
    assign wr_count = wr_pend_q && (wr_addr_q == TMRWG_OFF_COUNT);
    assign wr_clr = wr_pend_q && (wr_addr_q == TMRWG_OFF_IRQ_CLR);
    assign wr_en = wr_pend_q && (wr_addr_q == TMRWG_OFF_IRQ_EN);
    always_comb begin
        rdata_d = 32'h00000000;
        if (rd_addr == TMRWG_OFF_CTRL_A) begin
            rdata_d = {24'h000000, ctrl_a_q};
        end else if (rd_addr == TMRWG_OFF_CTRL_B) begin
            rdata_d = {24'h000000, ctrl_b_q};
        end else if (rd_addr == TMRWG_OFF_CMP_A) begin
            rdata_d = {16'h0000, cmp_a_buf_q};
        end else if (rd_addr == TMRWG_OFF_CMP_B) begin
            rdata_d = {16'h0000, cmp_b_buf_q};
        end else if (rd_addr == TMRWG_OFF_CAPT) begin
            rdata_d = {16'h0000, capt_q};
        end else if (rd_addr == TMRWG_OFF_COUNT) begin
            rdata_d = {16'h0000, cnt_q};
        end else if (rd_addr == TMRWG_OFF_IRQ_STAT) begin
            rdata_d = {29'h00000000, stat_q};
        end else if (rd_addr == TMRWG_OFF_IRQ_EN) begin
            rdata_d = {29'h00000000, irq_en_q};
        end
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q <= 32'h00000000;
        end else begin
            wr_pend_q <= take && hwrite;
            wr_addr_q <= rd_addr;
            if (take && !hwrite) begin
                rdata_q <= rdata_d;
            end
        end
    end
    // Zero wait states: every transfer completes in its first data phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    // ==========================================================
    // Control registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_a_q <= TMRWG_CTRL_RESET;
            ctrl_b_q <= TMRWG_CTRL_RESET;
            irq_en_q <= 3'h0;
            capt_q <= '0;
        end else begin
            if (wr_ctrl_a) begin
                ctrl_a_q <= hwdata[7:0] & TMRWG_CTRL_A_WMASK;
            end
            if (wr_ctrl_b) begin
                ctrl_b_q <= hwdata[7:0] & TMRWG_CTRL_B_WMASK;
            end
            if (wr_en) begin
                irq_en_q <= hwdata[2:0];
            end
            if (wr_capt) begin
                capt_q <= hwdata[CNT_W-1:0];
            end
        end
    end
    // ==========================================================
    // Mode decode
    logic [3:0] waveform_mode_select;
    logic [1:0] chan_a_output_action;
    logic [1:0] chan_b_output_action;
    logic [2:0] clock_source_select;
    tmrwg_mode_t mode;
    assign waveform_mode_select = {ctrl_b_q[TMRWG_B_MODE_LSB+:2], ctrl_a_q[1:0]};
    assign chan_a_output_action = ctrl_a_q[TMRWG_A_ACT_A_LSB+:2];
    assign chan_b_output_action = ctrl_a_q[TMRWG_A_ACT_B_LSB+:2];
    assign clock_source_select = ctrl_b_q[2:0];
    always_comb begin
        mode = '{TMRWG_KIND_NONPWM, TMRWG_TOP_FIXED, TMRWG_MAX, TMRWG_EVT_NOW,
            TMRWG_EVT_MAX, 1'b0};
        case (waveform_mode_select)
            4'h1: mode = '{TMRWG_KIND_DUAL, TMRWG_TOP_FIXED, TMRWG_TOP_8BIT, TMRWG_EVT_TOP,
                TMRWG_EVT_BOTTOM, 1'b0};
            4'h2: mode = '{TMRWG_KIND_DUAL, TMRWG_TOP_FIXED, TMRWG_TOP_9BIT, TMRWG_EVT_TOP,
                TMRWG_EVT_BOTTOM, 1'b0};
            4'h3: mode = '{TMRWG_KIND_DUAL, TMRWG_TOP_FIXED, TMRWG_TOP_10BIT, TMRWG_EVT_TOP,
                TMRWG_EVT_BOTTOM, 1'b0};
            4'h4: mode.top_src = TMRWG_TOP_CMPA;
            4'h5: mode = '{TMRWG_KIND_FAST, TMRWG_TOP_FIXED, TMRWG_TOP_8BIT, TMRWG_EVT_TOP,
                TMRWG_EVT_TOP, 1'b0};
            4'h6: mode = '{TMRWG_KIND_FAST, TMRWG_TOP_FIXED, TMRWG_TOP_9BIT, TMRWG_EVT_TOP,
                TMRWG_EVT_TOP, 1'b0};
            4'h7: mode = '{TMRWG_KIND_FAST, TMRWG_TOP_FIXED, TMRWG_TOP_10BIT, TMRWG_EVT_TOP,
                TMRWG_EVT_TOP, 1'b0};
            4'h8: mode = '{TMRWG_KIND_DUAL, TMRWG_TOP_CAPT, TMRWG_MAX, TMRWG_EVT_BOTTOM,
                TMRWG_EVT_BOTTOM, 1'b1};
            4'h9: mode = '{TMRWG_KIND_DUAL, TMRWG_TOP_CMPA, TMRWG_MAX, TMRWG_EVT_BOTTOM,
                TMRWG_EVT_BOTTOM, 1'b1};
            4'hA: mode = '{TMRWG_KIND_DUAL, TMRWG_TOP_CAPT, TMRWG_MAX, TMRWG_EVT_TOP,
                TMRWG_EVT_BOTTOM, 1'b1};
            4'hB: mode = '{TMRWG_KIND_DUAL, TMRWG_TOP_CMPA, TMRWG_MAX, TMRWG_EVT_TOP,
                TMRWG_EVT_BOTTOM, 1'b1};
            4'hC: mode.top_src = TMRWG_TOP_CAPT;
            4'hE: mode = '{TMRWG_KIND_FAST, TMRWG_TOP_CAPT, TMRWG_MAX, TMRWG_EVT_TOP,
                TMRWG_EVT_TOP, 1'b1};
            4'hF: mode = '{TMRWG_KIND_FAST, TMRWG_TOP_CMPA, TMRWG_MAX, TMRWG_EVT_TOP,
                TMRWG_EVT_TOP, 1'b1};
            default: ;
        endcase
    end
    // ==========================================================
    // Prescaler: clock select gives a one-cycle count enable
    logic [9:0] pre_q;
    logic tick;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pre_q <= 10'h000;
        end else begin
            pre_q <= pre_q + 10'h001;
        end
    end
    // External clock codes 6 and 7 are not wired here and stop the counter
    assign tick = (clock_source_select == 3'h1) ||
        (clock_source_select == 3'h2 && pre_q[2:0] == 3'h7) ||
        (clock_source_select == 3'h3 && pre_q[5:0] == 6'h3F) ||
        (clock_source_select == 3'h4 && pre_q[7:0] == 8'hFF) ||
        (clock_source_select == 3'h5 && pre_q == 10'h3FF);
    // ==========================================================
    // Counter and compare buffers
    logic [CNT_W-1:0] top;
    logic at_top;
    logic at_bottom;
    logic at_max;
    logic reload;
    logic ovf_evt;
    logic match_a;
    logic match_b;
    assign top = (mode.top_src == TMRWG_TOP_CMPA) ? cmp_a_q :
        (mode.top_src == TMRWG_TOP_CAPT) ? capt_q : mode.fixed_top[CNT_W-1:0];
    assign at_top = (cnt_q == top);
    assign at_bottom = (cnt_q == '0);
    assign at_max = (cnt_q == TMRWG_MAX[CNT_W-1:0]);
    assign reload = tick && ((mode.reload_at == TMRWG_EVT_TOP && at_top) ||
        (mode.reload_at == TMRWG_EVT_BOTTOM && at_bottom));
    assign ovf_evt = tick && ((mode.ovf_at == TMRWG_EVT_MAX && at_max) ||
        (mode.ovf_at == TMRWG_EVT_TOP && at_top) ||
        (mode.ovf_at == TMRWG_EVT_BOTTOM && at_bottom && !up_q));
    assign match_a = (cnt_q == cmp_a_q);
    assign match_b = (cnt_q == cmp_b_q);
    always_comb begin
        cnt_d = cnt_q + 1'b1;
        if (mode.kind == TMRWG_KIND_DUAL) begin
            cnt_d = (up_q && !at_top) || at_bottom ? cnt_q + 1'b1 : cnt_q - 1'b1;
        end else if ((at_top && mode.top_src != TMRWG_TOP_FIXED) ||
            (at_top && mode.kind != TMRWG_KIND_NONPWM)) begin
            cnt_d = '0;
        end
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
            up_q <= 1'b1;
            cmp_a_q <= '0;
            cmp_b_q <= '0;
            cmp_a_buf_q <= '0;
            cmp_b_buf_q <= '0;
        end else begin
            if (wr_count) begin
                cnt_q <= hwdata[CNT_W-1:0];
            end else if (tick) begin
                cnt_q <= cnt_d;
                if (at_top) begin
                    up_q <= 1'b0;
                end else if (at_bottom) begin
                    up_q <= 1'b1;
                end
            end
            if (wr_cmp_a) begin
                cmp_a_buf_q <= hwdata[CNT_W-1:0];
            end
            if (wr_cmp_b) begin
                cmp_b_buf_q <= hwdata[CNT_W-1:0];
            end
            if (reload || mode.reload_at == TMRWG_EVT_NOW) begin
                cmp_a_q <= cmp_a_buf_q;
                cmp_b_q <= cmp_b_buf_q;
            end
        end
    end
    // ==========================================================
    // Compare channels
    tmrwg_chan #(.IS_CHAN_A(1'b1)) u_chan_a (
        .mclk(mclk), .reset(reset), .mode(mode), .action(chan_a_output_action),
        .tick(tick), .match(match_a), .at_top(at_top), .at_bottom(at_bottom),
        .up(up_q), .cmp_is_top(cmp_a_q == top), .cmp_is_bot(cmp_a_q == '0),
        .port_data(port_data_a), .wave_out(chan_a_wave_out), .pin_out(pin_a_out),
        .connected(pin_a_connected)
    );
    tmrwg_chan #(.IS_CHAN_A(1'b0)) u_chan_b (
        .mclk(mclk), .reset(reset), .mode(mode), .action(chan_b_output_action),
        .tick(tick), .match(match_b), .at_top(at_top), .at_bottom(at_bottom),
        .up(up_q), .cmp_is_top(cmp_b_q == top), .cmp_is_bot(cmp_b_q == '0),
        .port_data(port_data_b), .wave_out(chan_b_wave_out), .pin_out(pin_b_out),
        .connected(pin_b_connected)
    );
    // ==========================================================
    // Interrupt status: set wins over a clear in the same cycle
    always_comb begin
        stat_d = stat_q & ~(wr_clr ? hwdata[2:0] : 3'h0);
        stat_d[TMRWG_IRQ_OVF] = stat_d[TMRWG_IRQ_OVF] | ovf_evt;
        stat_d[TMRWG_IRQ_MA] = stat_d[TMRWG_IRQ_MA] | (tick && match_a);
        stat_d[TMRWG_IRQ_MB] = stat_d[TMRWG_IRQ_MB] | (tick && match_b);
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            stat_q <= 3'h0;
        end else begin
            stat_q <= stat_d;
        end
    end
    assign irq = |(stat_q & irq_en_q);
    // ==========================================================
    // Checks
    chk_mode_form: assert property (@(posedge mclk) disable iff (reset)
        waveform_mode_select == {ctrl_b_q[4:3], ctrl_a_q[1:0]}) else $error("mode bits wrong");
    chk_ctrl_b_zero: assert property (@(posedge mclk) disable iff (reset)
        ctrl_b_q[5] == 1'b0) else $error("control b bit 5 not zero");
    chk_fast_ovf: assert property (@(posedge mclk) disable iff (reset)
        (tick && at_top && mode.kind == TMRWG_KIND_FAST) |=> stat_q[0]) else $error("no ovf at top");
    chk_dual_turn: assert property (@(posedge mclk) disable iff (reset)
        (tick && !wr_count && at_top && mode.kind == TMRWG_KIND_DUAL && top != '0) |=> !up_q)
        else $error("no turn at top");
    chk_reserved_mode: assert property (@(posedge mclk) disable iff (reset)
        waveform_mode_select == 4'hD |-> mode.kind == TMRWG_KIND_NONPWM) else $error("mode 13 wrong");
    chk_conn_a: assert property (@(posedge mclk) disable iff (reset)
        (mode.kind == TMRWG_KIND_NONPWM && chan_a_output_action != 2'h0) |-> pin_a_connected)
        else $error("channel a not connected");
    chk_b_toggle_off: assert property (@(posedge mclk) disable iff (reset)
        (mode.kind != TMRWG_KIND_NONPWM && chan_b_output_action == 2'h1) |-> !pin_b_connected)
        else $error("channel b toggle connected");
    chk_ctc_clear: assert property (@(posedge mclk) disable iff (reset)
        (tick && !wr_count && at_top && mode.kind == TMRWG_KIND_NONPWM) |=> cnt_q == '0)
        else $error("counter not cleared at top");
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking testbench for the timer waveform block
`timescale 1ns/1ps
`default_nettype none
module tb
    import tmrwg_pkg::*;
;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic pda = 1'b0;
    logic pdb = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, wa, wb, pa, pb, ca, cb, irq;
    int failures = 0;
    int n_compared = 0;
    logic [31:0] notes[$];
    logic [31:0] obs_v;
    event obs_ev;
    tmrwg_top tmrwg_top_inst (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .port_data_a(pda), .port_data_b(pdb), .chan_a_wave_out(wa), .chan_b_wave_out(wb),
        .pin_a_out(pa), .pin_b_out(pb), .pin_a_connected(ca), .pin_b_connected(cb),
        .irq(irq));
    initial begin
        forever #5 mclk = ~mclk;
    end
    // ====================
    // Checking
    always @(obs_ev) begin
        if (notes.size() > 0) begin
            check(obs_v, notes.pop_front());
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic post(input logic [31:0] seen, input logic [31:0] exp);
        notes.push_back(exp);
        obs_v = seen;
        ->obs_ev;
        #1;
    endtask
    task automatic pin_chk(input logic seen, input logic exp);
        post({31'h0, seen}, {31'h0, exp});
    endtask
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        end_of_test();
    end
    // ====================
    // Bus and sequencing
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        r = hrdata;
        // Let the write land before outputs are looked at
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0, x);
        post(x, e);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic do_reset();
        reset <= 1'b1;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
    endtask
    // Clock stopped throughout, so the compare outputs still hold their reset level
    task automatic modes();
        logic np, ea;
        wr(TMRWG_OFF_CMP_A, 32'h10);
        wr(TMRWG_OFF_CMP_B, 32'h10);
        for (int m = 0; m < 16; m++) begin
            pda <= 1'($urandom);
            pdb <= 1'($urandom);
            wr(TMRWG_OFF_CTRL_B, {27'h0, m[3:2], 3'h0});
            wr(TMRWG_OFF_CTRL_A, {24'h0, 4'h5, 2'h0, m[1:0]});
            np = m inside {0, 4, 12, 13};
            ea = np || (m >= 8 && m <= 11) || m >= 14;
            pin_chk(ca, ea);
            pin_chk(cb, np);
            pin_chk(pa, ea ? 1'b0 : pda);
            pin_chk(pb, np ? 1'b0 : pdb);
        end
        wr(TMRWG_OFF_CTRL_A, 32'h0);
        pin_chk(ca, 1'b0);
    endtask
    task automatic fast(input logic [1:0] c, input logic [15:0] v, input logic e1, e2);
        wr(TMRWG_OFF_CTRL_B, 32'h0);
        wr(TMRWG_OFF_CTRL_A, 32'h0);
        wr(TMRWG_OFF_CMP_A, {16'h0, v});
        wr(TMRWG_OFF_CMP_B, {16'h0, v});
        wr(TMRWG_OFF_COUNT, 32'hF0);
        wr(TMRWG_OFF_CTRL_A, {24'h0, c, c, 4'h1});
        wr(TMRWG_OFF_CTRL_B, 32'h09);
        wait_cyc(64);
        pin_chk(wa, e1);
        pin_chk(wb, e1);
        wait_cyc(128);
        pin_chk(wa, e2);
        pin_chk(wb, e2);
        $display("test done: fast pwm code %0d", c);
    endtask
    task automatic dual(input logic [1:0] c, input logic [15:0] v, input logic e1, e2);
        do_reset();
        wr(TMRWG_OFF_CMP_A, {16'h0, v});
        wr(TMRWG_OFF_CTRL_A, {24'h0, c, c, 4'h1});
        wr(TMRWG_OFF_CTRL_B, 32'h01);
        wait_cyc(192);
        pin_chk(wa, e1);
        pin_chk(wb, c[0]);
        wait_cyc(256);
        pin_chk(wa, e2);
        pin_chk(wb, c[0]);
        $display("test done: dual slope code %0d", c);
    endtask
    // Compare A at 0x0F makes TOP 0x0F, so the toggle period is 16 ticks
    task automatic clear_on_match_mode();
        do_reset();
        wr(TMRWG_OFF_CMP_A, 32'h0F);
        wr(TMRWG_OFF_CTRL_A, 32'h40);
        wr(TMRWG_OFF_CTRL_B, 32'h09);
        wait_cyc(24);
        pin_chk(wa, 1'b1);
        wait_cyc(16);
        pin_chk(wa, 1'b0);
        rd(TMRWG_OFF_COUNT, 32'h8);
        $display("test done: clear on match");
    endtask
    initial begin
        void'($urandom(49));
        do_reset();
        rd(TMRWG_OFF_CTRL_A, 32'h0);
        rd(TMRWG_OFF_CTRL_B, 32'h0);
        wr(TMRWG_OFF_CTRL_B, 32'hFF);
        rd(TMRWG_OFF_CTRL_B, 32'hDF);
        wr(TMRWG_OFF_CTRL_A, 32'hFF);
        rd(TMRWG_OFF_CTRL_A, 32'hF3);
        rd(8'h24, 32'h0);
        pin_chk(hresp, 1'b0);
        wr(TMRWG_OFF_CTRL_A, 32'h0);
        wr(TMRWG_OFF_CTRL_B, 32'h0);
        $display("test done: registers");
        modes();
        $display("test done: mode decode");
        fast(2'h2, 16'h00FF, 1'b1, 1'b1);
        fast(2'h2, 16'h0080, 1'b1, 1'b0);
        fast(2'h3, 16'h0080, 1'b0, 1'b1);
        wr(TMRWG_OFF_CTRL_B, 32'h08);
        rd(TMRWG_OFF_IRQ_STAT, 32'h7);
        pin_chk(irq, 1'b0);
        wr(TMRWG_OFF_IRQ_EN, 32'h1);
        pin_chk(irq, 1'b1);
        wr(TMRWG_OFF_IRQ_CLR, 32'h1);
        wr(TMRWG_OFF_IRQ_STAT, 32'h0);
        rd(TMRWG_OFF_IRQ_STAT, 32'h6);
        pin_chk(irq, 1'b0);
        wr(TMRWG_OFF_IRQ_CLR, 32'h6);
        rd(TMRWG_OFF_IRQ_STAT, 32'h0);
        $display("test done: interrupt");
        dual(2'h2, 16'h0080, 1'b0, 1'b1);
        dual(2'h3, 16'h0080, 1'b1, 1'b0);
        dual(2'h2, 16'h00FF, 1'b1, 1'b1);
        clear_on_match_mode();
        end_of_test();
    end
endmodule
`default_nettype wire
